// ==== shared/regmap_pkg.sv ====
// constants and types for the register map decoder
package regmap_pkg;
	localparam int REG_W = 16;
	localparam int ADDR_W = 16;
	localparam int BIT_SEL_W = 4;
	localparam logic [15:0] ROM_FIRST = 16'h0000;
	localparam logic [15:0] ROM_LAST = 16'h002f;
	localparam logic [15:0] CFG_FIRST = 16'h0064;
	localparam logic [15:0] CFG_LAST = 16'h00c8;
	localparam logic [15:0] RAM_FIRST = 16'h03e8;
	localparam logic [15:0] RAM_LAST = 16'h04e1;
	localparam int ROM_DEPTH = 48;
	localparam int CFG_DEPTH = 101;
	localparam int RAM_DEPTH = 250;
	localparam int CFG_DATA_W = 8;
	localparam logic [15:0] RAM_RESET_VAL = 16'h0000;
	localparam logic [7:0] CFG_RESET_VAL = 8'hff;
	localparam int DISPLAY_CHARS = 80;
	localparam logic [15:0] ROM_FILL = 16'h0000;
	typedef enum logic [1:0] {
		REGION_NONE,
		REGION_ROM,
		REGION_CFG,
		REGION_RAM
	} region_e;
	typedef enum logic [2:0] {
		OP_READ_REG,
		OP_WRITE_REG,
		OP_READ_BIT,
		OP_WRITE_BIT
	} op_e;
endpackage

// ==== shared/decode_if.sv ====
// carrier between the top and the address decoder
`timescale 1ns/1ps
interface decode_if;
	import regmap_pkg::*;
	logic [15:0] addr;
	region_e region;
	logic [15:0] offset;
	modport requester (output addr, input region, offset);
	modport decoder (input addr, output region, offset);
endinterface

// ==== logic/region_decoder.sv ====
// combinational split of a register address into region and offset
`timescale 1ns/1ps
module region_decoder (
	decode_if.decoder dif
);
	import regmap_pkg::*;
	always_comb begin
		dif.region = REGION_NONE;
		dif.offset = 16'h0000;
		if (dif.addr <= ROM_LAST) begin
			dif.region = REGION_ROM;
			dif.offset = dif.addr - ROM_FIRST;
		end else if (dif.addr >= CFG_FIRST && dif.addr <= CFG_LAST) begin
			dif.region = REGION_CFG;
			dif.offset = dif.addr - CFG_FIRST;
		end else if (dif.addr >= RAM_FIRST && dif.addr <= RAM_LAST) begin
			dif.region = REGION_RAM;
			dif.offset = dif.addr - RAM_FIRST;
		end
	end
endmodule

// ==== logic/modbus_register_map_decoder.sv ====
// register map of the slave: rom, configuration and ram blocks
`timescale 1ns/1ps
// Notes on behaviour
// - every register is sixteen bits, bit 0 least significant.
// - register addresses are sixteen bits, 0 to 65535.
// - single-bit reads and writes are accepted for coil and discrete functions.
// - rom 0-47, config 100-200, ram 1000-1249, other space unused.
// - reads of missing registers get no response at all.
// - display text packs two characters per word, eighty characters total.
// - written configuration takes effect only after a reset.
// - config keeps low byte only; upper byte ignored, reads as zero.
module modbus_register_map_decoder #(
	parameter int RAM_WORDS = regmap_pkg::RAM_DEPTH,
	parameter int CFG_WORDS = regmap_pkg::CFG_DEPTH
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic req_valid,
	input wire regmap_pkg::op_e req_op,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic [15:0] rom_rdata,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	output logic [15:0] rom_addr,
	output logic [15:0] cfg_active_word,
	output logic [15:0] cfg_active_addr_r_out,
	output logic [15:0] display_word,
	output logic [6:0] display_index
);
	import regmap_pkg::*;

	decode_if dif();
	// non-volatile store: it keeps its contents through nrst, so a write made
	// before a reset is what the live copy picks up after it
	logic [7:0] cfg_mem_r [CFG_WORDS] = '{default: CFG_RESET_VAL};
	logic [7:0] cfg_live_r [CFG_WORDS];
	logic [15:0] ram_mem_r [RAM_WORDS];
	logic [15:0] reg_addr;
	logic [3:0] bit_sel;
	logic bit_op;
	logic wr_op;
	logic [15:0] cur_word;
	logic [15:0] new_word;
	logic applied_r;
	logic [15:0] cfg_view_r;
	logic [15:0] disp_r;
	logic [6:0] disp_idx_r;
	logic hit;
	logic cfg_we;
	logic ram_we;
	logic disp_we;
	logic [6:0] cfg_idx;
	logic [7:0] ram_idx;
	logic [5:0] disp_off;

	// bit address to register; the bit is its low four bits
	function automatic logic [15:0] bit_to_reg(input logic [15:0] a);
		return {4'h0, a[15:4]};
	endfunction

	// word after a single-bit write: only the addressed bit changes
	function automatic logic [15:0] merge_bit(input logic [15:0] w, input logic [3:0] sel,
		input logic v);
		logic [15:0] r;
		r = w;
		r[sel] = v;
		return r;
	endfunction

	// what goes back to the master for an answered request
	function automatic logic [15:0] answer_word(input op_e op, input logic [15:0] w,
		input logic [3:0] sel, input logic [15:0] wd);
		logic [15:0] r;
		r = 16'h0000;
		case (op)
			OP_READ_REG: r = w;
			OP_READ_BIT: r = {15'h0000, w[sel]};
			OP_WRITE_REG: r = wd;
			OP_WRITE_BIT: r = wd;
			default: r = 16'h0000;
		endcase
		return r;
	endfunction

	assign bit_op = (req_op == OP_READ_BIT) || (req_op == OP_WRITE_BIT);
	assign wr_op = (req_op == OP_WRITE_REG) || (req_op == OP_WRITE_BIT);
	assign reg_addr = bit_op ? bit_to_reg(req_addr) : req_addr;
	assign bit_sel = req_addr[3:0];
	assign dif.addr = reg_addr;

	// region and offset of the register being addressed
	region_decoder u_dec (
		.dif(dif)
	);

	// narrow indices; each decoded offset fits the depth of its block
	assign cfg_idx = dif.offset[6:0];
	assign ram_idx = dif.offset[7:0];
	assign disp_off = dif.offset[5:0];

	// write strobes per block; rom and missing registers are never written
	always_comb begin
		hit = 1'b0;
		cfg_we = 1'b0;
		ram_we = 1'b0;
		disp_we = 1'b0;
		if (req_valid && dif.region != REGION_NONE) begin
			hit = 1'b1;
		end
		if (hit && wr_op) begin
			case (dif.region)
				REGION_CFG: cfg_we = 1'b1;
				REGION_RAM: ram_we = 1'b1;
				default: begin
					cfg_we = 1'b0;
					ram_we = 1'b0;
				end
			endcase
		end
		if (ram_we && dif.offset < 16'(DISPLAY_CHARS / 2)) begin
			disp_we = 1'b1;
		end
	end

	// current contents of the addressed register
	always_comb begin
		cur_word = 16'h0000;
		case (dif.region)
			REGION_ROM: cur_word = rom_rdata;
			REGION_CFG: cur_word = {8'h00, cfg_mem_r[cfg_idx]};
			REGION_RAM: cur_word = ram_mem_r[ram_idx];
			default: cur_word = 16'h0000;
		endcase
	end

	// bit writes read-modify-write the current word
	always_comb begin
		new_word = req_wdata;
		if (bit_op) new_word = merge_bit(cur_word, bit_sel, req_wdata[0]);
	end

	// stored configuration written by the master
	always_ff @(posedge core_clk) begin
		if (cfg_we) begin
			cfg_mem_r[cfg_idx] <= new_word[7:0];
		end
	end

	// live copy is loaded only on the first cycle after reset
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			applied_r <= 1'b0;
		end else begin
			applied_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int i = 0; i < CFG_WORDS; i++) cfg_live_r[i] <= CFG_RESET_VAL;
		end else if (!applied_r) begin
			for (int i = 0; i < CFG_WORDS; i++) cfg_live_r[i] <= cfg_mem_r[i];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int i = 0; i < RAM_WORDS; i++) ram_mem_r[i] <= RAM_RESET_VAL;
		end else if (ram_we) begin
			ram_mem_r[ram_idx] <= new_word;
		end
	end

	// answer only for existing registers
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0000;
		end else begin
			rsp_valid <= hit;
			if (hit) begin
				rsp_rdata <= answer_word(req_op, cur_word, bit_sel, req_wdata);
			end
		end
	end

	// address for the external rom; it trails the request by one cycle, so the
	// rom source must hold its data steady while a read is made
	always_ff @(posedge core_clk) begin
		if (!nrst) rom_addr <= 16'h0000;
		else rom_addr <= reg_addr;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cfg_view_r <= 16'h0000;
		end else begin
			cfg_view_r <= {8'h00, cfg_live_r[0]};
		end
	end
	assign cfg_active_word = cfg_view_r;

	always_ff @(posedge core_clk) begin
		if (!nrst) cfg_active_addr_r_out <= 16'h0000;
		else cfg_active_addr_r_out <= {8'h00, cfg_live_r[1]};
	end

	// each ram word written in the first 40 words of ram also goes out as two display characters
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			disp_r <= 16'h0000;
			disp_idx_r <= 7'h00;
		end else if (disp_we) begin
			disp_r <= new_word;
			disp_idx_r <= {disp_off, 1'b0};
		end
	end
	assign display_word = disp_r;
	assign display_index = disp_idx_r;
endmodule

// ==== tb/regmap_props.sv ====
// assertions on the register map decoder ports
`timescale 1ns/1ps
module regmap_props (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic req_valid,
	input wire regmap_pkg::op_e req_op,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_rdata
);
	import regmap_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic rg;
	logic [15:0] a;
	assign rg = req_valid && (req_op == OP_READ_REG || req_op == OP_WRITE_REG);
	assign a = req_addr;
	property p_rom; rg && a <= ROM_LAST |=> rsp_valid; endproperty
	a_rom: assert property (p_rom) else $error("rom access unanswered");
	property p_gap1; rg && a > ROM_LAST && a < CFG_FIRST |=> !rsp_valid; endproperty
	a_gap1: assert property (p_gap1) else $error("low gap answered");
	property p_cfg;
		req_valid && req_op == OP_READ_REG && a >= CFG_FIRST && a <= CFG_LAST
		|=> rsp_valid && rsp_rdata[15:8] == 8'h00;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config upper byte set");
	property p_gap2; rg && a > CFG_LAST && a < RAM_FIRST |=> !rsp_valid; endproperty
	a_gap2: assert property (p_gap2) else $error("mid gap answered");
	property p_high; rg && a > RAM_LAST |=> !rsp_valid; endproperty
	a_high: assert property (p_high) else $error("high space answered");
	property p_cause; rsp_valid |-> $past(req_valid); endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_echo;
		req_valid && req_op == OP_WRITE_REG && a >= RAM_FIRST && a <= RAM_LAST
		|=> rsp_rdata == $past(req_wdata);
	endproperty
	a_echo: assert property (p_echo) else $error("ram write data lost");
	property p_bit;
		req_valid && req_op == OP_READ_BIT && a[15:4] == 12'h3e9
		|=> rsp_valid && rsp_rdata[15:1] == 15'h0000;
	endproperty
	a_bit: assert property (p_bit) else $error("bit read malformed");
endmodule
bind modbus_register_map_decoder regmap_props regmap_props_inst (.core_clk(core_clk),
	.nrst(nrst), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
	.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

// ==== tb/master_model.sv ====
// bus master stand-in issuing one request at a time
`timescale 1ns/1ps
module master_model (
	input wire logic core_clk,
	output logic req_valid,
	output regmap_pkg::op_e req_op,
	output logic [15:0] req_addr,
	output logic [15:0] req_wdata
);
	import regmap_pkg::*;
	initial begin
		req_valid = 1'b0;
		req_op = OP_READ_REG;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
	end
	task automatic issue(input op_e o, input logic [15:0] ad, input logic [15:0] d);
		@(negedge core_clk);
		req_valid = 1'b1;
		req_op = o;
		req_addr = ad;
		req_wdata = d;
		@(negedge core_clk);
		req_valid = 1'b0;
		req_wdata = ~d;
	endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the register map decoder
`timescale 1ns/1ps
module tb_top;
	import regmap_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic req_valid, rsp_valid;
	op_e req_op;
	logic [15:0] req_addr, req_wdata, rsp_rdata, cfg_active_word, display_word;
	logic [15:0] rom_addr, cfg_active_addr;
	logic [15:0] rom_data = 16'h5a3c;
	logic [6:0] display_index;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	always #2.5 core_clk = ~core_clk;
	master_model master_model_inst (.core_clk(core_clk), .req_valid(req_valid),
		.req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata));
	modbus_register_map_decoder modbus_register_map_decoder_inst (.core_clk(core_clk),
		.nrst(nrst), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
		.req_wdata(req_wdata), .rom_rdata(rom_data), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rom_addr(rom_addr), .cfg_active_word(cfg_active_word),
		.cfg_active_addr_r_out(cfg_active_addr), .display_word(display_word),
		.display_index(display_index));
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_bounds;
		logic [15:0] a [11] = '{16'h002f, 16'h0030, 16'h0063, 16'h0064, 16'h00c8,
			16'h00c9, 16'h03e7, 16'h03e8, 16'h04e1, 16'h04e2, 16'hffff};
		logic [0:10] hit = 11'h4cc;
		for (int i = 0; i < 11; i++) begin
			master_model_inst.issue(OP_READ_REG, a[i], 16'h0000);
			chk("rsp_valid", {15'h0000, hit[i]}, {15'h0000, rsp_valid});
		end
	endtask
	task automatic t_cfg;
		master_model_inst.issue(OP_WRITE_REG, 16'h0064, 16'hab12);
		master_model_inst.issue(OP_READ_REG, 16'h0064, 16'h0000);
		chk("cfg", 16'h0012, rsp_rdata);
		chk("live", 16'h00ff, cfg_active_word);
		master_model_inst.issue(OP_WRITE_REG, 16'h0065, 16'h7734);
		chk("live1", 16'h00ff, cfg_active_addr);
		@(negedge core_clk);
		nrst = 1'b0;
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("applied", 16'h0012, cfg_active_word);
		chk("applied1", 16'h0034, cfg_active_addr);
		master_model_inst.issue(OP_READ_REG, 16'h0065, 16'h0000);
		chk("kept", 16'h0034, rsp_rdata);
	endtask
	task automatic t_rom;
		master_model_inst.issue(OP_READ_REG, 16'h0005, 16'h0000);
		chk("rom", 16'h5a3c, rsp_rdata);
		master_model_inst.issue(OP_READ_BIT, 16'h0052, 16'h0000);
		chk("rom_bit", 16'h0001, rsp_rdata);
		chk("rom_addr", 16'h0005, rom_addr);
		master_model_inst.issue(OP_READ_BIT, 16'h0300, 16'h0000);
		chk("gap_bit", 16'h0000, {15'h0000, rsp_valid});
	endtask
	task automatic t_ram;
		master_model_inst.issue(OP_WRITE_REG, 16'h03e9, 16'h4142);
		chk("disp", 16'h4142, display_word);
		chk("idx", 16'h0002, {9'h000, display_index});
		master_model_inst.issue(OP_READ_BIT, 16'h3e9e, 16'h0000);
		chk("bit", 16'h0001, rsp_rdata);
		chk("bit_reg", 16'h03e9, rom_addr);
		master_model_inst.issue(OP_WRITE_BIT, 16'h3e90, 16'h0001);
		master_model_inst.issue(OP_READ_REG, 16'h03e9, 16'h0000);
		chk("word", 16'h4143, rsp_rdata);
		master_model_inst.issue(OP_WRITE_REG, 16'h0410, 16'h2020);
		chk("disp_lim", 16'h4143, display_word);
		chk("idx_lim", 16'h0002, {9'h000, display_index});
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (5) @(negedge core_clk);
		nrst = 1'b1;
		t_bounds();
		t_cfg();
		t_rom();
		t_ram();
		tally_and_finish();
	end
endmodule
